// ===== rtl/pause_sync.sv
// two-flop synchroniser for a pin-level input
module pause_sync (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_async,
  output logic o_sync
);
  logic meta_r;

  // first flop feeds only the second one
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : pause_sync

// ===== rtl/pause_trigger_gating.sv
// pause-trigger gating of sampling, generation, pulse train and edge counting
// Operation
// (R1) output generation halts at once on pause
// (R2) internal clock: resume right at release
// (R3) external clock: resume at next edge after release; the first edge only clears rearm_r, the second resumes
// (R4) sampling also halts, same resume conditions
// (R5) pulse train freezes mid-pulse, then resumes
// (R6) paused phase is stretched by pause length
// (R7) edge counter ignores edges, keeps value
// (R8) scan finishes current sample before halting
// (R9) three-way: even, odd, compensation converters
// (R10) five-way: channel k to converter k mod 5
// (R11) paused clock edges start nothing, count nothing
module pause_trigger_gating #(
  parameter int SCAN_LEN = 4,
  parameter logic SAMPLE_HALT_EN = 1'b1
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic i_PAUSE,
  input wire logic i_EXT_SMP_CLK,
  input wire logic i_SRC_INTERNAL,
  input wire logic i_INT_TICK,
  input wire logic i_CTR_SRC,
  input wire logic i_RUN,
  input wire pause_gate_pkg::conv_var_e i_VARIANT,
  input wire logic i_CH_IS_CJC,
  input wire logic [pause_gate_pkg::PT_W-1:0] i_HIGH_TICKS,
  input wire logic [pause_gate_pkg::PT_W-1:0] i_LOW_TICKS,
  output logic o_PAUSED,
  output logic o_AO_UPDATE,
  output logic o_AI_CONVERT,
  output logic [pause_gate_pkg::CHAN_W-1:0] o_AI_CHAN,
  output logic [pause_gate_pkg::CONV_W-1:0] o_AI_CONV,
  output logic o_PULSE,
  output logic [pause_gate_pkg::CNT_W-1:0] o_COUNT,
  output logic [15:0] o_SAMPLES
);
  import pause_gate_pkg::*;

  logic pause_s;
  logic ext_s;
  logic ext_d_r;
  logic ctr_s;
  logic ctr_d_r;
  logic rearm_r;
  logic ext_edge;
  logic ctr_edge;
  logic tick;
  logic go;
  logic scan_busy_r;
  logic [CHAN_W-1:0] chan_r;
  logic [PT_W-1:0] phase_r;
  logic [CHAN_W-1:0] mod5;

  // pins from outside the clock domain get two flops first
  pause_sync u_sync_pause (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async(i_PAUSE),
    .o_sync(pause_s)
  );
  pause_sync u_sync_ext (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async(i_EXT_SMP_CLK),
    .o_sync(ext_s)
  );
  pause_sync u_sync_ctr (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async(i_CTR_SRC),
    .o_sync(ctr_s)
  );

  // rising-edge detectors on synchronised copies
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      ext_d_r <= 1'b0;
      ctr_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_s;
      ctr_d_r <= ctr_s;
    end
  end
  assign ext_edge = ext_s & ~ext_d_r;
  assign ctr_edge = ctr_s & ~ctr_d_r;

  // sample clock: internal tick enable or external edge
  assign tick = i_SRC_INTERNAL ? i_INT_TICK : ext_edge;

  // external source needs one clock edge after release to re-arm
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rearm_r <= 1'b0;
    end else if (pause_s && !i_SRC_INTERNAL) begin
      rearm_r <= 1'b1; // see (R3)
    end else if (ext_edge || i_SRC_INTERNAL) begin
      rearm_r <= 1'b0; // internal source resumes at release, see (R2)
    end
  end

  // a tick counts only when not paused and not waiting to re-arm
  assign go = i_RUN && tick && !pause_s && !rearm_r; // see (R11)
  assign o_PAUSED = pause_s || rearm_r;

  // output update strobe, registered, so cut one cycle after pause is seen
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      o_AO_UPDATE <= 1'b0;
    end else begin
      o_AO_UPDATE <= go; // see (R1)
    end
  end

  // sample count advances only on accepted ticks
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      o_SAMPLES <= SAMP_RST;
    end else if (go) begin
      o_SAMPLES <= o_SAMPLES + 16'h0001; // see (R11)
    end
  end

  // scan sequencer: once started, a sample runs over channels 1 to SCAN_LEN-1
  // even if pause arrives mid-scan; halting between channels would
  // leave a torn sample in the stream
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      scan_busy_r <= 1'b0;
      chan_r <= CHAN_RST;
      o_AI_CONVERT <= 1'b0;
    end else if (scan_busy_r) begin
      o_AI_CONVERT <= 1'b1; // see (R8)
      if (chan_r == CHAN_W'(SCAN_LEN - 1)) begin
        scan_busy_r <= 1'b0;
        chan_r <= CHAN_RST;
      end else begin
        chan_r <= chan_r + 5'h01;
      end
    end else if (go || (!SAMPLE_HALT_EN && i_RUN && tick)) begin
      o_AI_CONVERT <= 1'b0;
      scan_busy_r <= (SCAN_LEN > 1); // see (R4)
      chan_r <= (SCAN_LEN > 1) ? 5'h01 : CHAN_RST;
    end else begin
      o_AI_CONVERT <= 1'b0;
    end
  end

  // converter selection per variant
  assign mod5 = chan_r % CHAN_W'(CONV5_COUNT); // see (R10)
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      o_AI_CHAN <= CHAN_RST;
      o_AI_CONV <= 3'h0;
    end else begin
      o_AI_CHAN <= chan_r;
      unique case (i_VARIANT)
        VAR_THREE: begin
          if (i_CH_IS_CJC) begin
            o_AI_CONV <= CONV_W'(CONV3_CJC); // see (R9)
          end else if (chan_r[0]) begin
            o_AI_CONV <= CONV_W'(CONV3_ODD); // see (R9)
          end else begin
            o_AI_CONV <= CONV_W'(CONV3_EVEN); // see (R9)
          end
        end
        VAR_FIVE: begin
          o_AI_CONV <= mod5[CONV_W-1:0]; // see (R10)
        end
        default: begin
          o_AI_CONV <= 3'h0; // single shared converter
        end
      endcase
    end
  end

  // pulse train: phase counter frozen while paused, so the phase in
  // progress simply lasts longer by the pause length
  always_ff @(posedge I_CLK) begin
    if (I_SRST || !i_RUN) begin
      o_PULSE <= 1'b0;
      phase_r <= PT_RST;
    end else if (!pause_s) begin // see (R5)
      if (phase_r >= (o_PULSE ? i_HIGH_TICKS : i_LOW_TICKS)) begin
        o_PULSE <= ~o_PULSE;
        phase_r <= PT_RST;
      end else begin
        phase_r <= phase_r + 16'h0001; // see (R6)
      end
    end
  end

  // nonbuffered edge counter holds value across a pause
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      o_COUNT <= CNT_RST;
    end else if (i_RUN && ctr_edge && !pause_s) begin
      o_COUNT <= o_COUNT + 32'h0000_0001; // see (R7)
    end
  end
endmodule : pause_trigger_gating

// ===== shared/pause_gate_pkg.sv
// shared constants for the pause-trigger gating block
package pause_gate_pkg;
  localparam int CONV_W = 3;            // converter index width
  localparam int CHAN_W = 5;            // scan channel index width
  localparam int NUM_CHAN = 20;         // analog inputs on the widest variant
  localparam int CONV3_EVEN = 0;        // converter for even inputs
  localparam int CONV3_ODD = 1;         // converter for odd inputs
  localparam int CONV3_CJC = 2;         // converter for compensation channels
  localparam int CONV5_COUNT = 5;       // converters on the five-way variant
  localparam int CNT_W = 32;            // edge counter width
  localparam int PT_W = 16;             // pulse phase counter width
  localparam logic [31:0] CNT_RST = 32'h0000_0000;
  localparam logic [15:0] PT_RST = 16'h0000;
  localparam logic [4:0] CHAN_RST = 5'h00;
  localparam logic [15:0] SAMP_RST = 16'h0000;
  typedef enum logic [1:0] {
    VAR_PLAIN,
    VAR_THREE,
    VAR_FIVE
  } conv_var_e;
endpackage : pause_gate_pkg

// ===== verification/pause_props.sv
// concurrent checks on the pause gating ports
module pause_props #(
  parameter int SCAN_LEN = 4
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic i_PAUSE,
  input wire pause_gate_pkg::conv_var_e i_VARIANT,
  input wire logic o_PAUSED,
  input wire logic o_AO_UPDATE,
  input wire logic o_AI_CONVERT,
  input wire logic [4:0] o_AI_CHAN,
  input wire logic [2:0] o_AI_CONV,
  input wire logic o_PULSE,
  input wire logic [31:0] o_COUNT,
  input wire logic [15:0] o_SAMPLES
);
  import pause_gate_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  // pause windows of four or five cycles cover the two-flop pin delay
  upd_gated_a: assert property (
    o_AO_UPDATE |-> !$past(o_PAUSED))
    else $error("update while paused");
  samp_step_a: assert property (
    $changed(o_SAMPLES) |-> o_AO_UPDATE && o_SAMPLES == $past(o_SAMPLES) + 16'h0001)
    else $error("bad sample count");
  ao_stop_a: assert property (
    i_PAUSE [*4] |-> !o_AO_UPDATE)
    else $error("output not halted");
  cnt_stop_a: assert property (
    i_PAUSE [*5] |-> $stable(o_COUNT))
    else $error("edge counted in pause");
  cnt_step_a: assert property (
    $changed(o_COUNT) |-> o_COUNT == $past(o_COUNT) + 32'h1)
    else $error("count jumped");
  pulse_hold_a: assert property (
    i_PAUSE [*5] |-> $stable(o_PULSE))
    else $error("pulse moved in pause");
  // only an update outside a running scan starts one; updates during a scan leave it alone
  scan_walk_a: assert property (
    SCAN_LEN > 9 && o_AO_UPDATE && !o_AI_CONVERT |=>
    (o_AI_CONVERT && o_AI_CHAN == 5'h01) ##1 o_AI_CONVERT [*7])
    else $error("scan cut");
  map_five_a: assert property (
    o_AI_CONVERT && i_VARIANT == VAR_FIVE |-> o_AI_CONV == o_AI_CHAN % CONV5_COUNT)
    else $error("bad converter");
  cover property (o_AO_UPDATE);
  cover property ($fell(o_PAUSED));
  cover property (o_AI_CONVERT && i_VARIANT == VAR_THREE);
endmodule : pause_props
bind pause_trigger_gating pause_props #(.SCAN_LEN(SCAN_LEN)) i_pause_props (.I_CLK, .I_SRST,
  .i_PAUSE, .i_VARIANT, .o_PAUSED, .o_AO_UPDATE, .o_AI_CONVERT, .o_AI_CHAN, .o_AI_CONV, .o_PULSE,
  .o_COUNT, .o_SAMPLES);

// ===== verification/pause_src.sv
// external pause pin, sample clock and counter source
module pause_src (
  input wire logic i_clk,
  input wire logic i_pause_req,
  input wire logic i_clk_en,
  output logic o_pause,
  output logic o_ext_clk,
  output logic o_ctr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] div_r = 4'h0;
  // sample clock stands still low unless enabled; counter source runs free
  always @(posedge i_clk) begin
    div_r <= div_r + 4'h1;
    o_pause <= i_pause_req;
    o_ext_clk <= i_clk_en & div_r[2];
    o_ctr <= div_r[1];
  end
endmodule : pause_src

// ===== verification/tb_top.sv
// self-checking bench for the pause gating block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pause_gate_pkg::*;
  logic clk = 1'b0, srst = 1'b1, srst_d = 1'b1, tick = 1'b0, tick_d = 1'b0;
  logic src = 1'b1, src_d = 1'b1;
  logic cjc = 1'b0, cjc_d = 1'b0, pause_req = 1'b0, clk_en = 1'b0, pin, ext, ctr;
  conv_var_e variant = VAR_PLAIN, var_d = VAR_PLAIN;
  wire logic paused, upd, cnv, pulse;
  wire logic [4:0] chan;
  wire logic [2:0] conv;
  wire logic [31:0] cnt;
  wire logic [15:0] samp;
  int mismatches = 0, comparisons = 0, cycles = 0;
  always #10 clk = ~clk;
  // bench variables move at the falling edge and launch here, so nothing races the design
  always @(posedge clk) begin
    {srst, tick, src, cjc} <= {srst_d, tick_d, src_d, cjc_d};
    variant <= var_d;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  pause_src i_pause_src (.i_clk(clk), .i_pause_req(pause_req), .i_clk_en(clk_en),
    .o_pause(pin), .o_ext_clk(ext), .o_ctr(ctr));
  pause_trigger_gating #(.SCAN_LEN(20)) i_pause_trigger_gating (.I_CLK(clk), .I_SRST(srst),
    .i_PAUSE(pin), .i_EXT_SMP_CLK(ext), .i_SRC_INTERNAL(src), .i_INT_TICK(tick), .i_CTR_SRC(ctr),
    .i_RUN(1'b1), .i_VARIANT(variant), .i_CH_IS_CJC(cjc), .i_HIGH_TICKS(16'h0009),
    .i_LOW_TICKS(16'h0007), .o_PAUSED(paused), .o_AO_UPDATE(upd), .o_AI_CONVERT(cnv),
    .o_AI_CHAN(chan), .o_AI_CONV(conv), .o_PULSE(pulse), .o_COUNT(cnt), .o_SAMPLES(samp));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task tick_once;
    tick_d = 1'b1;
    cyc(1);
    tick_d = 1'b0;
  endtask : tick_once
  task t_int;
    logic [15:0] s0;
    s0 = samp;
    pause_req = 1'b1;
    cyc(5);
    tick_once();
    cyc(4);
    chk(samp === s0, "tick taken in pause");
    pause_req = 1'b0;
    cyc(4);
    chk(paused === 1'b0, "no resume");
    tick_once();
    cyc(1);
    chk(upd === 1'b1, "no update strobe");
    cyc(1);
    chk(samp === s0 + 16'h0001, "tick lost");
    cyc(25);
    $display("test internal done");
  endtask : t_int
  task t_ext;
    logic [15:0] s0;
    int n;
    src_d = 1'b0;
    pause_req = 1'b1;
    cyc(4);
    clk_en = 1'b1;
    cyc(2);
    s0 = samp;
    cyc(24);
    chk(samp === s0, "edge taken in pause");
    pause_req = 1'b0;
    for (n = 0; n < 40 && paused !== 1'b0; n++) cyc(1);
    chk(n < 40 && samp === s0, "release edge updated");
    cyc(14);
    chk(samp === s0 + 16'h0001, "no update after re-arm");
    clk_en = 1'b0;
    src_d = 1'b1;
    cyc(30);
    $display("test external done");
  endtask : t_ext
  task t_pulse;
    logic lvl;
    logic [31:0] c0;
    int n;
    lvl = pulse;
    for (n = 0; n < 40 && pulse === lvl; n++) cyc(1);
    lvl = pulse;
    n = 0;
    // a six-cycle pause placed inside one phase
    do begin
      cyc(1);
      n++;
      if (n == 1) pause_req = 1'b1;
      if (n == 7) pause_req = 1'b0;
    end while (pulse === lvl && n < 60);
    chk(n == (lvl ? 16 : 14), "phase not stretched");
    pause_req = 1'b1;
    cyc(4);
    c0 = cnt;
    cyc(20);
    chk(cnt === c0, "edges counted in pause");
    pause_req = 1'b0;
    cyc(15);
    chk(cnt >= c0 + 32'h3 && cnt <= c0 + 32'h4, "count not resumed");
    $display("test pulse done");
  endtask : t_pulse
  task t_scan(input conv_var_e v, input logic c);
    int n;
    logic [2:0] want;
    var_d = v;
    cjc_d = c;
    cyc(2);
    tick_once();
    pause_req = 1'b1;
    n = 0;
    repeat (30) begin
      cyc(1);
      if (cnv === 1'b1) begin
        n++;
        // plain variant shares one converter; three-way splits even, odd and compensation
        want = (v == VAR_FIVE) ? 3'(chan % CONV5_COUNT) : (v == VAR_PLAIN) ? 3'h0 :
          c ? 3'(CONV3_CJC) : chan[0] ? 3'(CONV3_ODD) : 3'(CONV3_EVEN);
        chk(conv === want, "conv");
      end
    end
    chk(n == 19, "scan cut by pause");
    pause_req = 1'b0;
    cyc(4);
    $display("test scan done");
  endtask : t_scan
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    cyc(6);
    srst_d = 1'b0;
    cyc(3);
    t_int();
    t_ext();
    t_pulse();
    t_scan(VAR_FIVE, 1'b0);
    t_scan(VAR_THREE, 1'b0);
    t_scan(VAR_THREE, 1'b1);
    t_scan(VAR_PLAIN, 1'b0);
    test_done();
  end
endmodule : tb_top
